// ===== phc_pkg.sv
// Purpose: shared constants and types of the panel config and halt block
// Assumes: AXI4-Lite register slave with 32-bit data, one clock
// Notes:   all offsets are byte addresses of aligned words
package phc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus
   localparam int         ADDR_W      = 8;
   localparam int         DATA_W      = 32;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_BDR  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0C;

   ////////////////////////////////////////////////////////////////////////
   // boot and diagnostic register layout, low twelve bits
   localparam int BDR_W    = 12;
   localparam int LED_W    = 4;
   localparam int LED_LSB  = 0;
   localparam int MODE_W   = 2;
   localparam int CPU_W    = 2;
   localparam int RATE_W   = 3;

   typedef struct packed {
      logic [RATE_W-1:0] rate;
      logic [CPU_W-1:0]  cpu;
      logic [MODE_W-1:0] mode;
      logic              permit;
      logic [LED_W-1:0]  led;
   } phc_bdr_t;

   // leds stored as pin levels: all low is all lit
   localparam logic [LED_W-1:0] LED_PIN_RST = 4'h0;
   localparam logic [CPU_W-1:0] CPU_NORMAL  = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // events, status and mask share this layout
   localparam int EV_W       = 3;
   localparam int EV_HALT    = 0;
   localparam int EV_RESTART = 1;
   localparam int EV_IGNORED = 2;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;
   localparam int CTRL_RESUME = 0;

   ////////////////////////////////////////////////////////////////////////
   // panel pins, all asynchronous to aclk
   typedef struct packed {
      logic              halt_permit_n;
      logic [MODE_W-1:0] power_up_mode_code_n;
      logic [CPU_W-1:0]  cpu_config_code_n;
      logic [RATE_W-1:0] console_rate_select_n;
      logic              bus_halt_n;
      logic              dc_power_good;
   } phc_pins_t;

   typedef enum logic {
      ST_RUN    = 1'b0,
      ST_HALTED = 1'b1
   } phc_state_t;

   ////////////////////////////////////////////////////////////////////////
   // console rate table, selected by the active-high rate code
   localparam int          DIV_W      = 17;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned BAUD_TAB [8] = '{300, 600, 1200, 2400,
                                            4800, 9600, 19200, 38400};

endpackage

// ===== phc_top.sv
// Purpose: panel configuration, diagnostic leds and halt arbitration
// Assumes: halt_instr and break_detect are one-cycle pulses on aclk
// Notes:   panel pins pass a two-flop synchroniser before any use
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module phc_top #(
   parameter int unsigned CLK_HZ = 250_000_000
) (
   // clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // axi4-lite write
   input  wire logic [phc_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [phc_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // axi4-lite read
   input  wire logic [phc_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [phc_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // panel
   input  wire phc_pkg::phc_pins_t            panel_pins,
   output logic [phc_pkg::LED_W-1:0]          diag_led_out_n,
   // processor side
   input  wire logic                          halt_instr,
   input  wire logic                          break_detect,
   output logic                               cpu_halted,
   output logic                               restart_req,
   output logic                               baud_tick,
   output logic                               irq
);

   ////////////////////////////////////////////////////////////////////////
   // decode shared by the read and write paths

   function automatic logic is_mapped(input logic [phc_pkg::ADDR_W-1:0] a);
      is_mapped = (a == phc_pkg::OFF_BDR) || (a == phc_pkg::OFF_STAT) ||
                  (a == phc_pkg::OFF_MASK) || (a == phc_pkg::OFF_CTRL);
   endfunction

   function automatic logic [phc_pkg::DIV_W-1:0] rate_div(
      input logic [phc_pkg::RATE_W-1:0] c);
      rate_div = phc_pkg::DIV_W'(CLK_HZ /
                 (phc_pkg::OVERSAMPLE * phc_pkg::BAUD_TAB[c]));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchronisers

   localparam int PIN_W = $bits(phc_pkg::phc_pins_t);
   logic [PIN_W-1:0]   pin_s1_q;
   logic [PIN_W-1:0]   pin_s2_q;
   phc_pkg::phc_pins_t pin_s;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            pin_s1_q[gi] <= panel_pins[gi];
            pin_s2_q[gi] <= pin_s1_q[gi];
         end
      end
   endgenerate

   assign pin_s = phc_pkg::phc_pins_t'(pin_s2_q);

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave, one write and one read in flight

   logic                         awready_q, wready_q, bvalid_q;
   logic                         arready_q, rvalid_q;
   logic                         aw_got_q, w_got_q;
   logic [phc_pkg::ADDR_W-1:0]   awaddr_q;
   logic [phc_pkg::DATA_W-1:0]   wdata_q;
   logic [3:0]                   wstrb_q;
   logic [1:0]                   bresp_q, rresp_q;
   logic [phc_pkg::DATA_W-1:0]   rdata_q;

   wire aw_hs    = s_axi_awvalid & awready_q;
   wire w_hs     = s_axi_wvalid & wready_q;
   wire wr_fire  = aw_got_q & w_got_q & ~bvalid_q;
   wire aw_got_d = (aw_got_q | aw_hs) & ~wr_fire;
   wire w_got_d  = (w_got_q | w_hs) & ~wr_fire;
   wire bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
   wire ar_hs    = s_axi_arvalid & arready_q;
   wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
   wire byte0    = wr_fire & wstrb_q[0];

   wire wr_bdr   = byte0 & (awaddr_q == phc_pkg::OFF_BDR);
   wire wr_stat  = byte0 & (awaddr_q == phc_pkg::OFF_STAT);
   wire wr_mask  = byte0 & (awaddr_q == phc_pkg::OFF_MASK);
   wire wr_ctrl  = byte0 & (awaddr_q == phc_pkg::OFF_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= phc_pkg::RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
      end else begin
         aw_got_q  <= aw_got_d;
         w_got_q   <= w_got_d;
         awready_q <= ~aw_got_d;
         wready_q  <= ~w_got_d;
         bvalid_q  <= bvalid_d;
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
         if (wr_fire) begin
            bresp_q <= is_mapped(awaddr_q) ? phc_pkg::RESP_OKAY
                                           : phc_pkg::RESP_SLVERR;
         end
      end
   end

   // payload registers need no reset; guarded by the got flags
   always_ff @(posedge aclk) begin
      if (aw_hs) begin
         awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // halt arbitration

   phc_pkg::phc_state_t state_q, state_d;
   logic                halted_q, restart_q, bus_halt_prev_q;

   wire permit     = ~pin_s.halt_permit_n;
   wire bus_halt   = ~pin_s.bus_halt_n;
   wire halt_go    = permit & (halt_instr | break_detect | bus_halt);
   wire reboot     = ~permit & halt_instr;
   wire ignored    = ~permit & (break_detect | (bus_halt & ~bus_halt_prev_q));
   wire resume     = wr_ctrl & wdata_q[phc_pkg::CTRL_RESUME];
   wire running    = (state_q == phc_pkg::ST_RUN);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         phc_pkg::ST_RUN: begin
            if (halt_go) begin
               state_d = phc_pkg::ST_HALTED;
            end
         end
         phc_pkg::ST_HALTED: begin
            // a fresh cause outranks a resume in the same cycle
            if (resume && !halt_go) begin
               state_d = phc_pkg::ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q         <= phc_pkg::ST_RUN;
         halted_q        <= 1'b0;
         restart_q       <= 1'b0;
         bus_halt_prev_q <= 1'b0;
      end else begin
         state_q         <= state_d;
         halted_q        <= (state_d == phc_pkg::ST_HALTED);
         restart_q       <= reboot & running;
         bus_halt_prev_q <= bus_halt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // diagnostic leds, held as pin levels

   logic [phc_pkg::LED_W-1:0] led_n_q;
   wire led_force = ~running & ~pin_s.dc_power_good;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         led_n_q <= phc_pkg::LED_PIN_RST;
      end else if (led_force) begin
         led_n_q <= phc_pkg::LED_PIN_RST;
      end else if (wr_bdr) begin
         led_n_q <= ~wdata_q[phc_pkg::LED_LSB +: phc_pkg::LED_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // events, status and interrupt

   logic [phc_pkg::EV_W-1:0] stat_q, mask_q;
   logic                     irq_q;
   logic [phc_pkg::EV_W-1:0] ev;

   assign ev[phc_pkg::EV_HALT]    = running & halt_go;
   assign ev[phc_pkg::EV_RESTART] = running & reboot;
   assign ev[phc_pkg::EV_IGNORED] = ignored;

   // set wins over a clearing write in the same cycle
   wire [phc_pkg::EV_W-1:0] stat_clr = wr_stat ? wdata_q[phc_pkg::EV_W-1:0]
                                               : phc_pkg::EV_RST;
   wire [phc_pkg::EV_W-1:0] stat_d   = (stat_q & ~stat_clr) | ev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= phc_pkg::EV_RST;
         mask_q <= phc_pkg::EV_RST;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr_mask) begin
            mask_q <= wdata_q[phc_pkg::EV_W-1:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // console rate divider, one-cycle enable at sixteen times the baud

   logic [phc_pkg::DIV_W-1:0] div_q;
   logic                      tick_q;
   wire  [phc_pkg::DIV_W-1:0] div_term = rate_div(~pin_s.console_rate_select_n);
   // compare with >= so a higher rate code never strands the counter
   wire                       div_end  = (div_q >= div_term - phc_pkg::DIV_W'(1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_end ? '0 : div_q + phc_pkg::DIV_W'(1);
         tick_q <= div_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   phc_pkg::phc_bdr_t bdr_view;
   assign bdr_view.led    = ~led_n_q;
   assign bdr_view.permit = pin_s.halt_permit_n;
   assign bdr_view.mode   = ~pin_s.power_up_mode_code_n;
   assign bdr_view.cpu    = ~pin_s.cpu_config_code_n;
   assign bdr_view.rate   = ~pin_s.console_rate_select_n;

   wire [phc_pkg::DATA_W-1:0] rd_word =
      (s_axi_araddr == phc_pkg::OFF_BDR)  ? phc_pkg::DATA_W'(bdr_view) :
      (s_axi_araddr == phc_pkg::OFF_STAT) ? phc_pkg::DATA_W'(stat_q)   :
      (s_axi_araddr == phc_pkg::OFF_MASK) ? phc_pkg::DATA_W'(mask_q)   :
      (s_axi_araddr == phc_pkg::OFF_CTRL) ? phc_pkg::DATA_W'(halted_q) :
                                            '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= '0;
         rresp_q <= phc_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rdata_q <= rd_word;
         rresp_q <= is_mapped(s_axi_araddr) ? phc_pkg::RESP_OKAY
                                            : phc_pkg::RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = wready_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign diag_led_out_n = led_n_q;
   assign cpu_halted     = halted_q;
   assign restart_req    = restart_q;
   assign baud_tick      = tick_q;
   assign irq            = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   led_reset_a: assert property ($rose(aresetn) |-> diag_led_out_n == '0)
      else $error("leds not lit after reset");

   led_force_a: assert property (halted_q && !pin_s.dc_power_good
      |=> diag_led_out_n == '0)
      else $error("leds not forced on power loss while halted");

   led_hold_a: assert property (!wr_bdr && !led_force |=> $stable(diag_led_out_n))
      else $error("leds changed without a write");

   led_write_a: assert property (wr_bdr && !led_force
      |=> diag_led_out_n == ~$past(wdata_q[phc_pkg::LED_W-1:0]))
      else $error("led write not reflected on pins");

   instr_halt_a: assert property (running && permit && halt_instr
      |=> cpu_halted && stat_q[phc_pkg::EV_HALT])
      else $error("halt instruction did not halt");

   break_halt_a: assert property (permit && break_detect |=> cpu_halted)
      else $error("break did not halt");

   bus_halt_a: assert property (permit && bus_halt |=> cpu_halted [*2])
      else $error("bus halt line did not hold halt");

   no_halt_a: assert property (running && !permit && !resume
      |=> !cpu_halted)
      else $error("halted while halt not permitted");

   restart_a: assert property (running && reboot |=> restart_req ##1 !restart_req)
      else $error("restart not a single pulse");

   rd_bdr_a: assert property (ar_hs && s_axi_araddr == phc_pkg::OFF_BDR
      |=> s_axi_rvalid && s_axi_rdata[phc_pkg::LED_W] == $past(pin_s.halt_permit_n))
      else $error("permit level misread");

   rd_codes_a: assert property (ar_hs && s_axi_araddr == phc_pkg::OFF_BDR
      |=> s_axi_rdata[phc_pkg::BDR_W-1:0] == $past(phc_pkg::BDR_W'(bdr_view)))
      else $error("panel codes misread");

   rate_tick_a: assert property (tick_q && !$changed(div_term)
      |=> !tick_q)
      else $error("rate enable wider than one cycle");

   sync_depth_a: assert property (pin_s2_q == $past(panel_pins, 2))
      else $error("panel input not delayed two flops");

endmodule // phc_top

// ===== phc_panel_model.sv
// Purpose: behavioural cover panel: switches, rate knob, halt line, lamps
// Assumes: settings arrive active high from the bench
// Notes:   no contact bounce; pins are steady levels between changes
`timescale 1ns/100ps
module phc_panel_model (
   // settings
   input  wire logic       permit_sw,
   input  wire logic [1:0] mode_sw,
   input  wire logic [1:0] cpu_sw,
   input  wire logic [2:0] rate_knob,
   input  wire logic       bus_halt,
   input  wire logic       power_ok,
   // cable
   input  wire logic [3:0] diag_led_out_n,
   output phc_pkg::phc_pins_t panel_pins,
   output logic [3:0]      lamps_lit
);
   // switches ground the wire, so every code arrives inverted
   assign panel_pins = {~permit_sw, ~mode_sw, ~cpu_sw, ~rate_knob, ~bus_halt, power_ok};
   assign lamps_lit  = ~diag_led_out_n;
endmodule // phc_panel_model

// ===== panel_config_halt_control_bench.sv
// Purpose: self-checking bench of the panel config and halt block
// Assumes: bench is the register bus master, panel model drives the pins
// Notes:   short clock figure so the slowest baud tick is 1024 cycles apart
`timescale 1ns/100ps
module panel_config_halt_control_bench;
   typedef struct {
      logic        permit;
      logic [1:0]  mode;
      logic [1:0]  cpu;
      logic [2:0]  rate;
      logic [31:0] boot_diag_reg;
      int          div;
   } phc_row_t;
   localparam int unsigned CLK_HZ = 4_915_200;
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs;
   logic        permit, bus_halt, power_ok, halt_instr, break_detect;
   logic [1:0]  mode, cpu;
   logic [2:0]  rate;
   logic [3:0]  led_n, lit;
   logic        cpu_halted, restart_req, baud_tick, irq;
   phc_pkg::phc_pins_t pins;
   int          n_fail, checks_done, n;
   phc_row_t    rows [4];

   ////////////////////////////////////////////////////////////////////////
   phc_top #(.CLK_HZ(CLK_HZ)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .panel_pins(pins), .diag_led_out_n(led_n),
      .halt_instr(halt_instr), .break_detect(break_detect),
      .cpu_halted(cpu_halted), .restart_req(restart_req),
      .baud_tick(baud_tick), .irq(irq));
   phc_panel_model panel (
      .permit_sw(permit), .mode_sw(mode), .cpu_sw(cpu), .rate_knob(rate),
      .bus_halt(bus_halt), .power_ok(power_ok), .diag_led_out_n(led_n),
      .panel_pins(pins), .lamps_lit(lit));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
      #1;
   endtask

   // no cycle count assumed: only the watchdog ends a wait
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic pulse(input bit brk);
      @(posedge aclk);
      if (brk) break_detect <= 1'b1;
      else halt_instr <= 1'b1;
      @(posedge aclk);
      halt_instr <= 1'b0;
      break_detect <= 1'b0;
      #1;
   endtask

   task automatic resume(input logic exp_halt);
      axi_wr(phc_pkg::OFF_CTRL, 32'h1, rs);
      cyc(2);
      chk(cpu_halted, exp_halt);
   endtask

   task automatic wait_tick(output int k);
      k = 0;
      do begin
         @(posedge aclk);
         #1;
         k++;
      end while (baud_tick !== 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_fail++;
      stop_test();
   end

   initial begin
      n_fail = 0;
      checks_done = 0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {halt_instr, break_detect, bus_halt, permit} = '0;
      {mode, cpu, rate} = '0;
      power_ok = 1'b1;
      // bit 4 carries the raw permit pin level: 1 means halts not permitted
      rows[0] = '{1'b0, 2'h0, 2'h0, 3'h0, 32'h0000000F, 1024};
      rows[1] = '{1'b1, 2'h1, 2'h0, 3'h1, 32'h0000023F, 512};
      rows[2] = '{1'b1, 2'h2, 2'h3, 3'h7, 32'h00000FDF, 8};
      rows[3] = '{1'b0, 2'h3, 2'h1, 3'h4, 32'h000008EF, 64};
      repeat (16) @(posedge aclk);
      chk(led_n, 4'h0);
      aresetn <= 1'b1;
      cyc(2);
      foreach (rows[i]) begin
         @(posedge aclk);
         permit <= ~rows[i].permit;
         mode <= rows[i].mode;
         cpu <= rows[i].cpu;
         rate <= rows[i].rate;
         cyc(4);
         axi_rd(phc_pkg::OFF_BDR, rd, rs);
         chk(rd, rows[i].boot_diag_reg);
         chk(rs, phc_pkg::RESP_OKAY);
         wait_tick(n);
         wait_tick(n);
         chk(n, rows[i].div);
         pulse(1'b0);
         chk(cpu_halted, !rows[i].permit);
         chk(restart_req, rows[i].permit);
         resume(1'b0);
         pulse(1'b1);
         chk(cpu_halted, !rows[i].permit);
         resume(1'b0);
         axi_rd(phc_pkg::OFF_STAT, rd, rs);
         chk(rd, rows[i].permit ? 32'h6 : 32'h1);
         axi_wr(phc_pkg::OFF_STAT, 32'h7, rs);
      end
      // panel churn and halts above must not have touched the leds
      chk(led_n, 4'h0);
      axi_wr(phc_pkg::OFF_BDR, 32'h5, rs);
      chk(rs, phc_pkg::RESP_OKAY);
      cyc(2);
      chk(led_n, 4'hA);
      chk(lit, 4'h5);
      @(posedge aclk);
      permit <= 1'b1;
      power_ok <= 1'b0;
      cyc(5);
      chk(led_n, 4'hA);
      pulse(1'b0);
      cyc(2);
      chk(led_n, 4'h0);
      @(posedge aclk);
      power_ok <= 1'b1;
      bus_halt <= 1'b1;
      cyc(4);
      chk(cpu_halted, 1'b1);
      resume(1'b1);
      @(posedge aclk);
      bus_halt <= 1'b0;
      cyc(4);
      resume(1'b0);
      @(posedge aclk);
      permit <= 1'b0;
      bus_halt <= 1'b1;
      cyc(5);
      chk(cpu_halted, 1'b0);
      @(posedge aclk);
      bus_halt <= 1'b0;
      axi_rd(phc_pkg::OFF_STAT, rd, rs);
      chk(rd, 32'h5);
      axi_wr(phc_pkg::OFF_MASK, 32'h4, rs);
      cyc(2);
      chk(irq, 1'b1);
      axi_wr(phc_pkg::OFF_STAT, 32'h4, rs);
      cyc(2);
      chk(irq, 1'b0);
      axi_rd(phc_pkg::OFF_STAT, rd, rs);
      chk(rd, 32'h1);
      axi_rd(phc_pkg::OFF_MASK, rd, rs);
      chk(rd, 32'h4);
      axi_wr(8'h10, 32'hF, rs);
      chk(rs, phc_pkg::RESP_SLVERR);
      axi_rd(8'h10, rd, rs);
      chk(rs, phc_pkg::RESP_SLVERR);
      chk(rd, 32'h0);
      stop_test();
   end
endmodule // panel_config_halt_control_bench
